//--- hw/ttc_defs.vh
// Register offsets, field positions and reset values for the triple timer/counter unit.
`ifndef TTC_DEFS_VH
`define TTC_DEFS_VH
`define TTC_ADDR_T01_CONTROL 8'h88
`define TTC_ADDR_T01_MODE 8'h89
`define TTC_ADDR_T0_LOW 8'h8a
`define TTC_ADDR_T1_LOW 8'h8b
`define TTC_ADDR_T0_HIGH 8'h8c
`define TTC_ADDR_T1_HIGH 8'h8d
`define TTC_ADDR_T2_CONTROL 8'hc8
`define TTC_ADDR_T2_RELOAD_LOW 8'hca
`define TTC_ADDR_T2_RELOAD_HIGH 8'hcb
`define TTC_ADDR_T2_LOW 8'hcc
`define TTC_ADDR_T2_HIGH 8'hcd
`define TTC_RESET_BYTE 8'h00
// Timer 0/1 control fields.
`define TTC_T01C_T1_OVF 7
`define TTC_T01C_T1_RUN 6
`define TTC_T01C_T0_OVF 5
`define TTC_T01C_T0_RUN 4
// Timer 0/1 mode fields, each timer has a nibble: gate, counter select, mode[1:0].
`define TTC_MODE_GATE 3
`define TTC_MODE_CSEL 2
`define TTC_MODE_13BIT 2'b00
`define TTC_MODE_16BIT 2'b01
`define TTC_MODE_RELOAD8 2'b10
`define TTC_MODE_SPLIT 2'b11
// Timer 2 control fields.
`define TTC_T2C_OVF 7
`define TTC_T2C_EXT_FLAG 6
`define TTC_T2C_RX_BAUD 5
`define TTC_T2C_TX_BAUD 4
`define TTC_T2C_EXT_EN 3
`define TTC_T2C_RUN 2
`define TTC_T2C_CSEL 1
`define TTC_T2C_CAP_SEL 0
`endif

//--- hw/ttc_edge_det.v
// Two-flop synchroniser with a falling-edge detector for one external pin.
`timescale 1ns/100ps
module ttc_edge_det (
    input wire clk_sys_in,
    input wire srst_in,
    input wire pin_in,
    output wire level_out,
    output wire fall_out
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    // The first stage feeds only the second; the edge is seen between sync and last.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign fall_out = last_q & ~sync_q;
endmodule

//--- hw/ttc_timer_unit.v
// Triple timer/counter unit: timers 0 and 1 with four modes, timer 2 with reload, capture and baud modes.
//
// Summary of operation
// - Mode 0 counts 13 bits: full high byte plus low five bits of low byte.
// - Mode 0 leaves low byte's upper three bits unchanged; software ignores them.
// - Counter wrap from all ones to zero sets that timer's overflow flag, except timer 1 while timer 0 is in mode 3.
// - Count passes only with run set and gate clear or gate pin high, except timer 1 and timer 0 high byte while timer 0 is in mode 3.
// - Setting a run bit keeps the counter contents as they are.
// - Timer function counts every core clock, no divide-by-twelve stage.
// - Mode 1 is mode 0 but with all sixteen counter bits.
// - Mode 2 low byte overflow sets flag and reloads it from high byte.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Timer 0 mode 3 low byte uses timer 0 controls, pin and flag.
// - Timer 0 mode 3 high byte counts clocks with timer 1 run and flag.
// - Timer 1 then starts leaving mode 3, stops entering it, still gives baud ticks.
// - Timer 2 mode: off, autoreload, capture or baud, from run, baud and capture bits.
// - Timer 2 autoreload rollover sets overflow flag and loads reload pair.
// - Autoreload with trigger enable: falling trigger pin reloads and sets edge flag.
// - Capture mode counts 16 bits; overflow sets timer 2 overflow flag.
// - Capture with trigger enable: falling trigger pin captures counter, sets edge flag.
// - Baud mode never sets timer 2 overflow flag.
// - Baud mode still lets the edge flag be set by the trigger pin.
// - Baud select set ignores capture select and reloads on every overflow.
// - Timer 2 counter select picks count pin when set, core clock when clear.
`timescale 1ns/100ps
`include "ttc_defs.vh"
module ttc_timer_unit (
    input wire clk_sys_in,
    input wire srst_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire gate0_pin_in,
    input wire gate1_pin_in,
    input wire count0_pin_in,
    input wire count1_pin_in,
    input wire timer2_count_pin_in,
    input wire external_trigger_pin_in,
    output reg timer0_overflow_flag_out,
    output reg timer1_overflow_flag_out,
    output reg timer2_irq_out,
    output reg timer1_baud_tick_out,
    output reg timer2_baud_tick_out
);
    reg [7:0] t01_control_q;
    reg [7:0] t01_mode_q;
    reg [7:0] t0_low_q;
    reg [7:0] t0_high_q;
    reg [7:0] t1_low_q;
    reg [7:0] t1_high_q;
    reg [7:0] t2_control_q;
    reg [7:0] t2_reload_low_q;
    reg [7:0] t2_reload_high_q;
    reg [7:0] t2_low_q;
    reg [7:0] t2_high_q;

    wire gate0_lvl;
    wire gate1_lvl;
    wire cnt0_fall;
    wire cnt1_fall;
    wire cnt2_fall;
    wire trig_fall;

    // External pins: synchronised, and count pins edge-detected.
    ttc_edge_det u_gate0 (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pin_in(gate0_pin_in),
        .level_out(gate0_lvl), .fall_out());
    ttc_edge_det u_gate1 (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pin_in(gate1_pin_in),
        .level_out(gate1_lvl), .fall_out());
    ttc_edge_det u_cnt0 (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pin_in(count0_pin_in),
        .level_out(), .fall_out(cnt0_fall));
    ttc_edge_det u_cnt1 (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pin_in(count1_pin_in),
        .level_out(), .fall_out(cnt1_fall));
    ttc_edge_det u_cnt2 (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pin_in(timer2_count_pin_in),
        .level_out(), .fall_out(cnt2_fall));
    ttc_edge_det u_trig (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .pin_in(external_trigger_pin_in),
        .level_out(), .fall_out(trig_fall));

    // Field decode of the mode register; timer 0 in the low nibble, timer 1 in the high.
    wire [1:0] mode0 = t01_mode_q[1:0];
    wire [1:0] mode1 = t01_mode_q[5:4];
    wire csel0 = t01_mode_q[`TTC_MODE_CSEL];
    wire csel1 = t01_mode_q[`TTC_MODE_CSEL + 4];
    wire gate0 = t01_mode_q[`TTC_MODE_GATE];
    wire gate1 = t01_mode_q[`TTC_MODE_GATE + 4];
    wire run0 = t01_control_q[`TTC_T01C_T0_RUN];
    wire run1 = t01_control_q[`TTC_T01C_T1_RUN];
    wire split0 = (mode0 == `TTC_MODE_SPLIT);

    wire tick0 = run0 & (~gate0 | gate0_lvl) & (csel0 ? cnt0_fall : 1'b1);
    // high byte of split timer 0 counts clocks on timer 1 run.
    wire tick0h = split0 & run1;
    // timer 1 holds in mode 3
    // timer 1 run follows mode 3
    wire tick1 = (split0 ? 1'b1 : run1) & (mode1 != `TTC_MODE_SPLIT) & (~gate1 | gate1_lvl) &
        (csel1 ? cnt1_fall : 1'b1);

    // Timer 2 mode decode.
    wire t2_run = t2_control_q[`TTC_T2C_RUN];
    wire t2_baud = t2_control_q[`TTC_T2C_RX_BAUD] | t2_control_q[`TTC_T2C_TX_BAUD];
    wire t2_exten = t2_control_q[`TTC_T2C_EXT_EN];
    wire t2_capture = t2_run & ~t2_baud & t2_control_q[`TTC_T2C_CAP_SEL];
    wire t2_reload_mode = t2_run & ~t2_capture;
    wire tick2 = t2_run & (t2_control_q[`TTC_T2C_CSEL] ? cnt2_fall : 1'b1);
    wire [15:0] t2_count = {t2_high_q, t2_low_q};
    wire t2_wrap = tick2 & (t2_count == 16'hffff);
    wire t2_trig = t2_exten & trig_fall;

    // Write decodes.
    wire wr_t01c = wr_in & (addr_in == `TTC_ADDR_T01_CONTROL);
    wire wr_t0l = wr_in & (addr_in == `TTC_ADDR_T0_LOW);
    wire wr_t0h = wr_in & (addr_in == `TTC_ADDR_T0_HIGH);
    wire wr_t1l = wr_in & (addr_in == `TTC_ADDR_T1_LOW);
    wire wr_t1h = wr_in & (addr_in == `TTC_ADDR_T1_HIGH);
    wire wr_t2c = wr_in & (addr_in == `TTC_ADDR_T2_CONTROL);
    wire wr_t2l = wr_in & (addr_in == `TTC_ADDR_T2_LOW);
    wire wr_t2h = wr_in & (addr_in == `TTC_ADDR_T2_HIGH);

    // Timer 0 next state and overflow event.
    reg [7:0] t0_low_d;
    reg [7:0] t0_high_d;
    reg t0_ovf_evt;
    reg t0h_ovf_evt;
    always @* begin
        t0_low_d = t0_low_q;
        t0_high_d = t0_high_q;
        t0_ovf_evt = 1'b0;
        t0h_ovf_evt = 1'b0;
        if (tick0) begin
            case (mode0)
                `TTC_MODE_13BIT: begin
                    if (t0_low_q[4:0] == 5'h1f) begin
                        t0_high_d = t0_high_q + 8'h01;
                        t0_ovf_evt = (t0_high_q == 8'hff);
                    end
                    t0_low_d = {t0_low_q[7:5], t0_low_q[4:0] + 5'h01};
                end
                `TTC_MODE_16BIT: begin
                    {t0_high_d, t0_low_d} = {t0_high_q, t0_low_q} + 16'h0001;
                    t0_ovf_evt = ({t0_high_q, t0_low_q} == 16'hffff);
                end
                `TTC_MODE_RELOAD8: begin
                    t0_ovf_evt = (t0_low_q == 8'hff);
                    t0_low_d = t0_ovf_evt ? t0_high_q : t0_low_q + 8'h01;
                end
                default: begin
                    t0_low_d = t0_low_q + 8'h01;
                    t0_ovf_evt = (t0_low_q == 8'hff);
                end
            endcase
        end
        if (tick0h) begin
            t0_high_d = t0_high_q + 8'h01;
            t0h_ovf_evt = (t0_high_q == 8'hff);
        end
    end

    // Timer 1 next state; its overflow gives the baud tick as well.
    reg [7:0] t1_low_d;
    reg [7:0] t1_high_d;
    reg t1_ovf_evt;
    always @* begin
        t1_low_d = t1_low_q;
        t1_high_d = t1_high_q;
        t1_ovf_evt = 1'b0;
        if (tick1) begin
            case (mode1)
                `TTC_MODE_13BIT: begin
                    if (t1_low_q[4:0] == 5'h1f) begin
                        t1_high_d = t1_high_q + 8'h01;
                        t1_ovf_evt = (t1_high_q == 8'hff);
                    end
                    t1_low_d = {t1_low_q[7:5], t1_low_q[4:0] + 5'h01};
                end
                `TTC_MODE_16BIT: begin
                    {t1_high_d, t1_low_d} = {t1_high_q, t1_low_q} + 16'h0001;
                    t1_ovf_evt = ({t1_high_q, t1_low_q} == 16'hffff);
                end
                `TTC_MODE_RELOAD8: begin
                    t1_ovf_evt = (t1_low_q == 8'hff);
                    t1_low_d = t1_ovf_evt ? t1_high_q : t1_low_q + 8'h01;
                end
                default: begin
                    t1_low_d = t1_low_q;
                end
            endcase
        end
    end

    // split high byte owns timer 1 flag
    wire t1_flag_evt = split0 ? t0h_ovf_evt : t1_ovf_evt;

    // Timer 0/1 registers; a counter write wins over counting in the same cycle.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            t01_control_q <= `TTC_RESET_BYTE;
            t01_mode_q <= `TTC_RESET_BYTE;
            t0_low_q <= `TTC_RESET_BYTE;
            t0_high_q <= `TTC_RESET_BYTE;
            t1_low_q <= `TTC_RESET_BYTE;
            t1_high_q <= `TTC_RESET_BYTE;
        end else begin
            if (wr_in && addr_in == `TTC_ADDR_T01_MODE) begin
                t01_mode_q <= wdata_in;
            end
            // run bit write touches no counter
            if (wr_t01c) begin
                t01_control_q <= wdata_in;
            end
            if (t0_ovf_evt) begin
                t01_control_q[`TTC_T01C_T0_OVF] <= 1'b1;
            end
            if (t1_flag_evt) begin
                t01_control_q[`TTC_T01C_T1_OVF] <= 1'b1;
            end
            t0_low_q <= wr_t0l ? wdata_in : t0_low_d;
            t0_high_q <= wr_t0h ? wdata_in : t0_high_d;
            t1_low_q <= wr_t1l ? wdata_in : t1_low_d;
            t1_high_q <= wr_t1h ? wdata_in : t1_high_d;
        end
    end

    // Timer 2 registers.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            t2_control_q <= `TTC_RESET_BYTE;
            t2_reload_low_q <= `TTC_RESET_BYTE;
            t2_reload_high_q <= `TTC_RESET_BYTE;
            t2_low_q <= `TTC_RESET_BYTE;
            t2_high_q <= `TTC_RESET_BYTE;
        end else begin
            // flags cleared only by software write
            if (wr_t2c) begin
                t2_control_q <= wdata_in;
            end
            if (t2_wrap && !t2_baud) begin
                t2_control_q[`TTC_T2C_OVF] <= 1'b1;
            end
            // edge flag in every running mode
            if (t2_trig && t2_run) begin
                t2_control_q[`TTC_T2C_EXT_FLAG] <= 1'b1;
            end
            if (wr_in && addr_in == `TTC_ADDR_T2_RELOAD_LOW) begin
                t2_reload_low_q <= wdata_in;
            end
            if (wr_in && addr_in == `TTC_ADDR_T2_RELOAD_HIGH) begin
                t2_reload_high_q <= wdata_in;
            end
            if (t2_capture && t2_trig) begin
                t2_reload_low_q <= t2_low_q;
                t2_reload_high_q <= t2_high_q;
            end
            if (t2_reload_mode && (t2_wrap || (t2_trig && !t2_baud))) begin
                t2_low_q <= t2_reload_low_q;
                t2_high_q <= t2_reload_high_q;
            end else if (tick2) begin
                {t2_high_q, t2_low_q} <= t2_count + 16'h0001;
            end
            if (wr_t2l) begin
                t2_low_q <= wdata_in;
            end
            if (wr_t2h) begin
                t2_high_q <= wdata_in;
            end
        end
    end

    // Read port: data stand in the cycle after the strobe; unmapped reads return zero.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdata_out <= `TTC_RESET_BYTE;
        end else if (rd_in) begin
            case (addr_in)
                `TTC_ADDR_T01_CONTROL: rdata_out <= t01_control_q;
                `TTC_ADDR_T01_MODE: rdata_out <= t01_mode_q;
                `TTC_ADDR_T0_LOW: rdata_out <= t0_low_q;
                `TTC_ADDR_T1_LOW: rdata_out <= t1_low_q;
                `TTC_ADDR_T0_HIGH: rdata_out <= t0_high_q;
                `TTC_ADDR_T1_HIGH: rdata_out <= t1_high_q;
                `TTC_ADDR_T2_CONTROL: rdata_out <= t2_control_q;
                `TTC_ADDR_T2_RELOAD_LOW: rdata_out <= t2_reload_low_q;
                `TTC_ADDR_T2_RELOAD_HIGH: rdata_out <= t2_reload_high_q;
                `TTC_ADDR_T2_LOW: rdata_out <= t2_low_q;
                `TTC_ADDR_T2_HIGH: rdata_out <= t2_high_q;
                default: rdata_out <= `TTC_RESET_BYTE;
            endcase
        end else begin
            rdata_out <= `TTC_RESET_BYTE;
        end
    end

    // Flag and baud tick outputs, all registered.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            timer0_overflow_flag_out <= 1'b0;
            timer1_overflow_flag_out <= 1'b0;
            timer2_irq_out <= 1'b0;
            timer1_baud_tick_out <= 1'b0;
            timer2_baud_tick_out <= 1'b0;
        end else begin
            timer0_overflow_flag_out <= t01_control_q[`TTC_T01C_T0_OVF];
            timer1_overflow_flag_out <= t01_control_q[`TTC_T01C_T1_OVF];
            timer2_irq_out <= t2_control_q[`TTC_T2C_OVF] | t2_control_q[`TTC_T2C_EXT_FLAG];
            // baud tick survives mode 3 split
            timer1_baud_tick_out <= t1_ovf_evt;
            timer2_baud_tick_out <= t2_wrap & t2_baud;
        end
    end
endmodule

//--- dv/ttc_timer_unit_props.sv
// Port assertions for the triple timer/counter unit, bound to its top module.
`timescale 1ns/100ps
`include "ttc_defs.vh"
module ttc_timer_unit_props (
    input wire clk_sys_in,
    input wire srst_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire external_trigger_pin_in,
    input wire timer0_overflow_flag_out,
    input wire timer2_irq_out,
    input wire timer1_baud_tick_out
);
    reg [7:0] t2c_q;
    wire t2_wr = wr_in && (addr_in == `TTC_ADDR_T2_CONTROL);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    // Shadow of the last value software wrote to the timer 2 control register.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            t2c_q <= 8'h00;
        end else if (t2_wr) begin
            t2c_q <= wdata_in;
        end
    end
    sequence mode_wr_s;
        wr_in && (addr_in == `TTC_ADDR_T01_MODE);
    endsequence
    sequence mode_rd_s;
        rd_in && !wr_in && (addr_in == `TTC_ADDR_T01_MODE);
    endsequence
    // Read data stands for one cycle only; otherwise the bus reads zero.
    rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    mode_readback_a: assert property (mode_wr_s ##1 mode_rd_s |=> rdata_out == $past(wdata_in, 2))
        else $error("mode register read back differs from write");
    flag0_set_a: assert property (
        wr_in && addr_in == `TTC_ADDR_T01_CONTROL && wdata_in[`TTC_T01C_T0_OVF] |-> ##2 timer0_overflow_flag_out)
        else $error("timer 0 flag output did not follow the register");
    t1_hold_a: assert property (
        wr_in && addr_in == `TTC_ADDR_T01_MODE && wdata_in[5:4] == 2'b11 |-> ##3 (!timer1_baud_tick_out) [*4])
        else $error("timer 1 ticked while held in mode 3");
    baud_noflag_a: assert property (
        t2c_q[5:4] != 2'b00 && t2c_q[7:6] == 2'b00 && !t2c_q[3] && !t2_wr |=> !timer2_irq_out)
        else $error("timer 2 request raised in baud mode");
    t2_off_quiet_a: assert property (
        !t2c_q[2] && t2c_q[7:6] == 2'b00 && !t2_wr |=> !timer2_irq_out)
        else $error("timer 2 request raised while off");
    trig_edge_a: assert property (
        $fell(external_trigger_pin_in) && t2c_q[5:2] == 4'b0011 && t2c_q[7:6] == 2'b00 |-> ##[2:8] timer2_irq_out)
        else $error("trigger edge set no request in reload or capture");
    baud_edge_a: assert property (
        $fell(external_trigger_pin_in) && t2c_q[5:4] != 2'b00 && t2c_q[3:2] == 2'b11 |-> ##[2:8] timer2_irq_out)
        else $error("trigger edge set no request in baud mode");
endmodule
bind ttc_timer_unit ttc_timer_unit_props chk (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .external_trigger_pin_in(external_trigger_pin_in),
    .timer0_overflow_flag_out(timer0_overflow_flag_out), .timer2_irq_out(timer2_irq_out),
    .timer1_baud_tick_out(timer1_baud_tick_out)
);

//--- dv/ttc_pin_model.sv
// Model of the external gate, count and trigger pins around the timer unit.
`timescale 1ns/100ps
module ttc_pin_model (
    input wire clk_sys_in,
    output logic [5:0] pins_out
);
    // Pins idle high: gates open, no edge pending on count or trigger inputs.
    initial pins_out = 6'h3f;
    // Holds one pin at a steady level from the next edge on.
    // gate level
    task set_pin(input int idx, input logic lvl);
        pins_out[idx] <= lvl;
    endtask
    // Falling edges, each level held three clocks so the synchronisers see it.
    // falling edges
    task pulse(input int idx, input int n);
        repeat (n) begin
            pins_out[idx] <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
            pins_out[idx] <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
        end
    endtask
endmodule

//--- dv/ttc_timer_unit_test.sv
// Self-checking bench for the triple timer/counter unit.
`timescale 1ns/100ps
`include "ttc_defs.vh"
module ttc_timer_unit_test;
    reg clk_sys_in = 1'b0;
    reg srst_in = 1'b1;
    reg [7:0] addr_q = 8'h00;
    reg [7:0] wdata_q = 8'h00;
    reg wr_q = 1'b0;
    reg rd_q = 1'b0;
    wire [7:0] rdata;
    wire [5:0] pins;
    wire t0_flag;
    wire t1_flag;
    wire t2_irq;
    wire baud1;
    wire baud2;
    int baud1_n = 0;
    int baud2_n = 0;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] got;
    // Register rows: address, value written, value read back.
    logic [23:0] regs [0:11] = '{24'h88_2f2f, 24'h89_a5a5, 24'h8a_1111, 24'h8b_2222, 24'h8c_3333,
        24'h8d_4444, 24'hc8_3939, 24'hca_3434, 24'hcb_1212, 24'hcc_6666, 24'hcd_7777, 24'h90_5500};
    // Counter rows: control, low, high, setup address and value, run, gate, preload low and high,
    // expected low and high, expected control while running, low byte mask.
    logic [103:0] runs [0:12] = '{
        104'h88_8a8c_8900_1001_1aff_0900_301f,
        104'h88_8a8c_8901_1001_f8ff_0700_30ff,
        104'h88_8a8c_8902_1001_fa80_8980_30ff,
        104'h88_8a8c_8909_1000_0500_0500_10ff,
        104'h88_8a8c_8909_1001_0500_1400_10ff,
        104'h88_8b8d_8910_4001_f8ff_0700_c0ff,
        104'h88_8b8d_8930_4001_1234_1234_40ff,
        104'h88_8a8c_8903_4001_55f8_5507_c0ff,
        104'hc8_cccd_ca34_0401_f8ff_3b12_84ff,
        104'hc8_cccd_ca34_3501_f8ff_3b12_35ff,
        104'hc8_cccd_ca34_0501_f8ff_0700_85ff,
        104'hc8_cccd_ca34_0101_f8ff_f8ff_01ff,
        104'hc8_cccd_ca34_0601_f8ff_f8ff_06ff};
    // Trigger rows: control, low preload, address read, expected byte.
    logic [31:0] trg [0:2] = '{32'h0f5a_ca5a, 32'h0e11_cc5a, 32'h3e11_cc11};
    ttc_pin_model pins_m (.clk_sys_in(clk_sys_in), .pins_out(pins));
    ttc_timer_unit dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .addr_in(addr_q), .wdata_in(wdata_q),
        .wr_in(wr_q), .rd_in(rd_q), .rdata_out(rdata), .gate0_pin_in(pins[0]), .gate1_pin_in(pins[1]),
        .count0_pin_in(pins[2]), .count1_pin_in(pins[3]), .timer2_count_pin_in(pins[4]),
        .external_trigger_pin_in(pins[5]), .timer0_overflow_flag_out(t0_flag),
        .timer1_overflow_flag_out(t1_flag), .timer2_irq_out(t2_irq),
        .timer1_baud_tick_out(baud1), .timer2_baud_tick_out(baud2)
    );
    // Counts the one-cycle baud tick pulses of both timers.
    always @(posedge clk_sys_in) begin
        if (baud1 === 1'b1) baud1_n++;
        if (baud2 === 1'b1) baud2_n++;
    end
    // Free-running core clock.
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [7:0] fld(input logic [103:0] r, input int k);
        return r[103 - 8 * k -: 8];
    endfunction
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One-cycle write; a second write in a row waits an edge so the strobe drops between.
    task wr(input logic [7:0] a, input logic [7:0] d);
        if (wr_q) @(posedge clk_sys_in);
        addr_q <= a;
        wdata_q <= d;
        wr_q <= 1'b1;
        @(posedge clk_sys_in);
        wr_q <= 1'b0;
    endtask
    // One-cycle read; data is taken in the following cycle and compared under a mask.
    task rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        addr_q <= a;
        rd_q <= 1'b1;
        @(posedge clk_sys_in);
        rd_q <= 1'b0;
        @(posedge clk_sys_in);
        got = rdata;
        chk(got & m, e & m);
    endtask
    // Preloads a counter, runs it for fifteen edges, reads the control mid-run, then stops it.
    task run_row(input logic [103:0] r);
        pins_m.set_pin(0, fld(r, 6) != 8'h00);
        pins_m.set_pin(1, fld(r, 6) != 8'h00);
        wr(fld(r, 3), fld(r, 4));
        wr(fld(r, 1), fld(r, 7));
        wr(fld(r, 2), fld(r, 8));
        wr(fld(r, 0), fld(r, 5));
        repeat (12) @(posedge clk_sys_in);
        rdc(fld(r, 0), fld(r, 11), 8'hff);
        if (fld(r, 0) == `TTC_ADDR_T01_CONTROL) begin
            chk({t1_flag, 1'b0, t0_flag, 5'h00}, fld(r, 11) & 8'ha0);
        end else begin
            chk({7'h00, t2_irq}, fld(r, 11) >> 7);
        end
        wr(fld(r, 0), 8'h00);
        rdc(fld(r, 1), fld(r, 9), fld(r, 12));
        rdc(fld(r, 2), fld(r, 10), 8'hff);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #100_000;
        fail_count++;
        end_sim();
    end
    // Main sequence: register table, counter rows, then edge-driven cases.
    initial begin
        repeat (16) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        @(posedge clk_sys_in);
        for (int i = 0; i < 12; i++) begin
            rdc(regs[i][23:16], 8'h00, 8'hff);
            wr(regs[i][23:16], regs[i][15:8]);
            rdc(regs[i][23:16], regs[i][7:0], 8'hff);
        end
        for (int i = 0; i < 13; i++) begin
            run_row(runs[i]);
        end
        // Counter function on the count pin: exactly three edges, no core clocks.
        wr(`TTC_ADDR_T01_MODE, 8'h05);
        wr(`TTC_ADDR_T0_LOW, 8'h00);
        wr(`TTC_ADDR_T01_CONTROL, 8'h10);
        pins_m.pulse(2, 3);
        repeat (4) @(posedge clk_sys_in);
        wr(`TTC_ADDR_T01_CONTROL, 8'h00);
        rdc(`TTC_ADDR_T0_LOW, 8'h03, 8'hff);
        // Trigger edges in capture, reload and baud modes with the counter frozen.
        for (int i = 0; i < 3; i++) begin
            wr(`TTC_ADDR_T2_LOW, trg[i][23:16]);
            wr(`TTC_ADDR_T2_CONTROL, trg[i][31:24]);
            pins_m.pulse(5, 1);
            rdc(`TTC_ADDR_T2_CONTROL, trg[i][31:24] | 8'h40, 8'hff);
            chk({7'h00, t2_irq}, 8'h01);
            rdc(trg[i][15:8], trg[i][7:0], 8'hff);
            wr(`TTC_ADDR_T2_CONTROL, 8'h00);
        end
        // One timer 1 wrap in its 16-bit row, one timer 2 wrap in its baud row.
        chk(baud1_n[7:0], 8'h01);
        chk(baud2_n[7:0], 8'h01);
        // Reset with the timer 0 flag set: control returns to zero, timer 0 flag output stays low.
        wr(`TTC_ADDR_T01_CONTROL, 8'h20);
        srst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        @(posedge clk_sys_in);
        rdc(`TTC_ADDR_T01_CONTROL, 8'h00, 8'hff);
        chk({7'h00, t0_flag}, 8'h00);
        end_sim();
    end
endmodule
